// ==== drw_drive.sv ====
/*
 * drive end: acts on remote write words and requests.
 * assumes the master keeps words stable while a request is high.
 */
// The placing of the registers and register access over APB were decided locally.
// Contract
// - monitor request fills first two readback words
// - ram request stores volatile, eeprom stores persistent
// - write set point first; done after store
// - set point is unsigned 0.01 Hz, max 59000
// - torque mode for ext 0,1,12 and source 3,5; code also requires sensorless_vec_i high
// - torque write updates both torque parameters
// - instruction runs only after execute request
// - instruction done only after full execution
// - nonzero ext: upper byte is link extension
// - operand and instruction set before execute
// - master loads zero operand when unused
// - monitor request fills readback words four to seven
// - done drops when execute request clears
// - master accesses only while station ready
`timescale 1ns/100ps
`include "drw_regs.svh"
module drw_drive
	import drw_pkg::*;
#(
	parameter int EEP_CYC = `DRW_EEP_CYC
) (
	// clock and reset
	input  wire logic         core_clk_i,
	input  wire logic         rst_i,
	input  wire logic         clk_en_i,
	// drive settings
	input  wire logic [7:0]   ext_setting_sel_i,
	input  wire logic [7:0]   torque_src_sel_i,
	input  wire logic         sensorless_vec_i,
	input  wire logic         drive_fault_i,
	// monitored data source, indexed by monitor code
	output      logic [15:0]  mon_code_o,
	input  wire logic [15:0]  mon_data_i,
	// stored values
	output      logic [15:0]  freq_ram_o,
	output      logic [15:0]  freq_eep_o,
	output      logic [15:0]  torque_cmd_volatile_param_o,
	output      logic [15:0]  torque_cmd_persistent_param_o,
	// instruction execution
	output      logic         ins_strobe_o,
	output      logic [7:0]   ins_code_o,
	output      logic [7:0]   ins_link_ext_o,
	output      logic [15:0]  ins_operand_o,
	// link
	drw_link_if.drive         lnk
);
	drw_state_t st_r;
	logic [15:0] cnt_r;
	logic        is_eep_r;
	logic [2:0]  mon_idx_r;
	logic        mon_busy_r;
	logic [15:0] ins_cnt_r;
	logic        ins_busy_r;
	logic        torque_mode;
	logic [2:0]  mon_word;

	assign torque_mode = sensorless_vec_i &&
		(ext_setting_sel_i == `DRW_EXT_ZERO ||
		 ext_setting_sel_i == `DRW_EXT_ONE ||
		 ext_setting_sel_i == `DRW_EXT_TWELVE) &&
		(torque_src_sel_i == `DRW_TSRC_THREE ||
		 torque_src_sel_i == `DRW_TSRC_FIVE);

	// fault drops the ready interlock
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i)
			lnk.station_ready_flag <= 1'b0;
		else if (clk_en_i)
			lnk.station_ready_flag <= !drive_fault_i;
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_r                          <= DRW_IDLE;
			cnt_r                         <= 16'h0000;
			is_eep_r                      <= 1'b0;
			lnk.ram_write_done            <= 1'b0;
			lnk.eeprom_write_done         <= 1'b0;
			freq_ram_o                    <= 16'h0000;
			freq_eep_o                    <= 16'h0000;
			torque_cmd_volatile_param_o   <= 16'h0000;
			torque_cmd_persistent_param_o <= 16'h0000;
		end else if (clk_en_i) begin
			unique case (st_r)
			DRW_IDLE: begin
				if (lnk.eeprom_write_request) begin
					st_r     <= DRW_BUSY;
					is_eep_r <= 1'b1;
					cnt_r    <= 16'(EEP_CYC);
				end else if (lnk.ram_write_request) begin
					st_r     <= DRW_BUSY;
					is_eep_r <= 1'b0;
					cnt_r    <= 16'(`DRW_RAM_CYC);
				end
			end
			DRW_BUSY: begin
				if (cnt_r > 16'h0001) begin
					cnt_r <= cnt_r - 16'h0001;
				end else begin
					st_r <= DRW_DONE;
					if (torque_mode) begin
						torque_cmd_volatile_param_o   <= lnk.wr_word[`DRW_W_SETPOINT];
						torque_cmd_persistent_param_o <= lnk.wr_word[`DRW_W_SETPOINT];
					end else if (lnk.wr_word[`DRW_W_SETPOINT] <= `DRW_FREQ_MAX) begin
						if (is_eep_r)
							freq_eep_o <= lnk.wr_word[`DRW_W_SETPOINT];
						freq_ram_o <= lnk.wr_word[`DRW_W_SETPOINT];
					end
					if (is_eep_r)
						lnk.eeprom_write_done <= 1'b1;
					else
						lnk.ram_write_done <= 1'b1;
				end
			end
			DRW_DONE: begin
				if (is_eep_r ? !lnk.eeprom_write_request
				             : !lnk.ram_write_request) begin
					st_r                  <= DRW_IDLE;
					lnk.ram_write_done    <= 1'b0;
					lnk.eeprom_write_done <= 1'b0;
				end
			end
			default: st_r <= DRW_IDLE;
			endcase
		end
	end

	// readback word index of a scan step
	assign mon_word = mon_idx_r;
	always_comb begin
		unique case (mon_idx_r)
		3'h0: mon_code_o = {8'h00, lnk.wr_word[`DRW_W_MON_A][7:0]};
		3'h1: mon_code_o = {8'h00, lnk.wr_word[`DRW_W_MON_A][15:8]};
		3'h4: mon_code_o = lnk.wr_word[`DRW_W_MON_C];
		3'h5: mon_code_o = lnk.wr_word[`DRW_W_MON_D];
		3'h6: mon_code_o = lnk.wr_word[`DRW_W_MON_E];
		default: mon_code_o = lnk.wr_word[`DRW_W_MON_F];
		endcase
	end

	// scan codes into words zero, one and four to seven
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mon_idx_r        <= 3'h0;
			mon_busy_r       <= 1'b0;
			lnk.monitor_done <= 1'b0;
			for (int i = 0; i < 8; i++)
				lnk.rd_word[i] <= 16'h0000;
		end else if (clk_en_i) begin
			if (!lnk.monitor_request) begin
				mon_busy_r       <= 1'b0;
				lnk.monitor_done <= 1'b0;
				mon_idx_r        <= 3'h0;
			end else if (!mon_busy_r && !lnk.monitor_done) begin
				mon_busy_r <= 1'b1;
				mon_idx_r  <= 3'h0;
			end else if (mon_busy_r) begin
				lnk.rd_word[mon_word] <= mon_data_i;
				if (mon_idx_r == 3'h7) begin
					mon_busy_r       <= 1'b0;
					lnk.monitor_done <= 1'b1;
				end else if (mon_idx_r == 3'h1) begin
					mon_idx_r <= 3'h4;
				end else begin
					mon_idx_r <= mon_idx_r + 3'h1;
				end
			end
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ins_busy_r           <= 1'b0;
			ins_cnt_r            <= 16'h0000;
			ins_strobe_o         <= 1'b0;
			ins_code_o           <= 8'h00;
			ins_link_ext_o       <= 8'h00;
			ins_operand_o        <= 16'h0000;
			lnk.instruction_done <= 1'b0;
		end else if (clk_en_i) begin
			ins_strobe_o <= 1'b0;
			if (!lnk.instruction_execute_request) begin
				ins_busy_r           <= 1'b0;
				lnk.instruction_done <= 1'b0;
			end else if (!ins_busy_r && !lnk.instruction_done) begin
				ins_busy_r   <= 1'b1;
				ins_cnt_r    <= 16'(`DRW_INS_CYC);
				ins_strobe_o <= 1'b1;
				ins_operand_o <= lnk.wr_word[`DRW_W_OPERAND];
				if (ext_setting_sel_i != `DRW_EXT_ZERO) begin
					ins_link_ext_o <= lnk.wr_word[`DRW_W_INSTR][15:8];
					ins_code_o     <= lnk.wr_word[`DRW_W_INSTR][7:0];
				end else begin
					ins_link_ext_o <= 8'h00;
					ins_code_o     <= lnk.wr_word[`DRW_W_INSTR][7:0];
				end
			end else if (ins_busy_r) begin
				if (ins_cnt_r > 16'h0001) begin
					ins_cnt_r <= ins_cnt_r - 16'h0001;
				end else begin
					ins_busy_r           <= 1'b0;
					lnk.instruction_done <= 1'b1;
				end
			end
		end
	end
endmodule

// ==== drw_link_if.sv ====
/*
 * link between the master end and the drive end: eight remote
 * write words, request and done bits, readback words.
 * assumes both ends share core_clk_i.
 */
`timescale 1ns/100ps
interface drw_link_if;
	import drw_pkg::*;
	drw_word_t  wr_word [8];
	drw_word_t  rd_word [8];
	logic       monitor_request;
	logic       ram_write_request;
	logic       eeprom_write_request;
	logic       instruction_execute_request;
	logic       ram_write_done;
	logic       eeprom_write_done;
	logic       instruction_done;
	logic       monitor_done;
	logic       station_ready_flag;

	modport master (
		output wr_word, monitor_request, ram_write_request,
		       eeprom_write_request, instruction_execute_request,
		input  rd_word, ram_write_done, eeprom_write_done,
		       instruction_done, monitor_done, station_ready_flag
	);
	modport drive (
		input  wr_word, monitor_request, ram_write_request,
		       eeprom_write_request, instruction_execute_request,
		output rd_word, ram_write_done, eeprom_write_done,
		       instruction_done, monitor_done, station_ready_flag
	);
endinterface

// ==== drw_link_sva.sv ====
/* checker of the link between the two ends: requests, done bits
 and ready. assumes the clock enable held high. */
`timescale 1ns/100ps
module drw_link_sva
	import drw_pkg::*;
(
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// requests
	input wire logic monitor_request,
	input wire logic ram_write_request,
	input wire logic eeprom_write_request,
	input wire logic instruction_execute_request,
	// answers
	input wire logic monitor_done,
	input wire logic ram_write_done,
	input wire logic eeprom_write_done,
	input wire logic instruction_done,
	input wire logic station_ready_flag
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	sequence s_ram_go;
		$rose(ram_write_request) && !eeprom_write_request &&
		!ram_write_done && !eeprom_write_done;
	endsequence
	sequence s_quiet(r);
		!r ##1 !r;
	endsequence
	AST_READY_GATE: assert property (
		(monitor_request || ram_write_request || eeprom_write_request ||
		instruction_execute_request) |-> station_ready_flag)
		else $error("request passed without ready");
	AST_RAM_BOUND: assert property (s_ram_go |-> ##[1:14] ram_write_done)
		else $error("ram done late");
	AST_RAM_SLOW: assert property (
		$rose(ram_write_done) |-> $past(ram_write_request, 5))
		else $error("ram done too early");
	AST_RAM_HOLD: assert property (
		ram_write_done && ram_write_request |=> ram_write_done)
		else $error("ram done dropped early");
	AST_RAM_CLR: assert property (
		s_quiet(ram_write_request) |-> !ram_write_done)
		else $error("ram done stuck");
	AST_EEP_SLOW: assert property (
		$rose(eeprom_write_done) |-> $past(eeprom_write_request, 4))
		else $error("eeprom done too early");
	AST_EEP_CLR: assert property (
		s_quiet(eeprom_write_request) |-> !eeprom_write_done)
		else $error("eeprom done stuck");
	AST_INS_SLOW: assert property (
		$rose(instruction_done) |-> $past(instruction_execute_request, 16))
		else $error("instruction done too early");
	AST_INS_BOUND: assert property (
		$rose(instruction_execute_request) && !instruction_done |->
		##[1:30] instruction_done)
		else $error("instruction done late");
	AST_INS_CLR: assert property (
		s_quiet(instruction_execute_request) |-> !instruction_done)
		else $error("instruction done stuck");
	AST_MON_BOUND: assert property (
		$rose(monitor_request) && !monitor_done |-> ##[1:12] monitor_done)
		else $error("monitor done late");
endmodule

// ==== drw_master.sv ====
/*
 * master end: apb slave registers drive the remote words and
 * request bits; status and readback words are read back.
 * assumes software follows the write-then-request order.
 */
`timescale 1ns/100ps
`include "drw_regs.svh"
module drw_master
	import drw_pkg::*;
(
	// clock and reset
	input  wire logic         core_clk_i,
	input  wire logic         rst_i,
	input  wire logic         clk_en_i,
	// apb slave
	input  wire logic         psel_i,
	input  wire logic         penable_i,
	input  wire logic         pwrite_i,
	input  wire logic [7:0]   paddr_i,
	input  wire logic [31:0]  pwdata_i,
	output      logic [31:0]  prdata_o,
	output      logic         pready_o,
	output      logic         pslverr_o,
	// link
	drw_link_if.master        lnk
);
	logic        wr_en;
	logic [31:0] rd_val;
	logic [3:0]  ctrl_r;

	assign pready_o  = 1'b1;
	assign wr_en     = psel_i && penable_i && pwrite_i && clk_en_i;
	assign prdata_o  = rd_val;

	assign lnk.monitor_request             = ctrl_r[`DRW_B_MON] &&
		lnk.station_ready_flag;
	assign lnk.ram_write_request           = ctrl_r[`DRW_B_RAM] &&
		lnk.station_ready_flag;
	assign lnk.eeprom_write_request        = ctrl_r[`DRW_B_EEP] &&
		lnk.station_ready_flag;
	assign lnk.instruction_execute_request = ctrl_r[`DRW_B_INS] &&
		lnk.station_ready_flag;

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_r <= 4'h0;
			for (int i = 0; i < 8; i++)
				lnk.wr_word[i] <= 16'h0000;
		end else if (wr_en) begin
			if (paddr_i == `DRW_A_CTRL)
				ctrl_r <= pwdata_i[3:0];
			else if (paddr_i[7:5] == 3'h0 && paddr_i[1:0] == 2'h0)
				lnk.wr_word[paddr_i[4:2]] <= pwdata_i[15:0];
		end
	end

	always_comb begin
		rd_val    = 32'h0000_0000;
		pslverr_o = 1'b0;
		if (paddr_i == `DRW_A_CTRL)
			rd_val = {28'h0000000, ctrl_r};
		else if (paddr_i == `DRW_A_STATUS)
			rd_val = {27'h0000000, lnk.station_ready_flag,
				lnk.instruction_done, lnk.eeprom_write_done,
				lnk.ram_write_done, lnk.monitor_done};
		else if (paddr_i[7:5] == 3'h0 && paddr_i[1:0] == 2'h0)
			rd_val = {16'h0000, lnk.wr_word[paddr_i[4:2]]};
		else if (paddr_i[7:5] == 3'h2 && paddr_i[1:0] == 2'h0)
			rd_val = {16'h0000, lnk.rd_word[paddr_i[4:2]]};
		else
			pslverr_o = psel_i && penable_i;
	end
endmodule

// ==== drw_pkg.sv ====
/*
 * types shared by both ends of the remote write link.
 * assumes nothing beyond the constants header.
 */
package drw_pkg;
	typedef logic [15:0] drw_word_t;
	typedef enum logic [1:0] {
		DRW_IDLE = 2'b00,
		DRW_BUSY = 2'b01,
		DRW_DONE = 2'b11
	} drw_state_t;
endpackage

// ==== drw_regs.svh ====
/*
 * constants for the remote write register block: word indices,
 * field positions, codes and timing counts.
 * assumes a 10 MHz core clock.
 */
`ifndef DRW_REGS_SVH
`define DRW_REGS_SVH

// remote word indices on the link
`define DRW_W_MON_A      3'h0
`define DRW_W_SETPOINT   3'h1
`define DRW_W_INSTR      3'h2
`define DRW_W_OPERAND    3'h3
`define DRW_W_MON_C      3'h4
`define DRW_W_MON_D      3'h5
`define DRW_W_MON_E      3'h6
`define DRW_W_MON_F      3'h7

// apb offsets of the controller registers
`define DRW_A_WORD0      8'h00
`define DRW_A_CTRL       8'h20
`define DRW_A_STATUS     8'h24
`define DRW_A_RDBK0      8'h40

// control / status bit positions
`define DRW_B_MON        0
`define DRW_B_RAM        1
`define DRW_B_EEP        2
`define DRW_B_INS        3
`define DRW_B_READY      4

// set point and selection codes
`define DRW_FREQ_MAX     16'hE678
`define DRW_EXT_ZERO     8'h00
`define DRW_EXT_ONE      8'h01
`define DRW_EXT_TWELVE   8'h0C
`define DRW_TSRC_THREE   8'h03
`define DRW_TSRC_FIVE    8'h05

// store and instruction service times
`define DRW_RAM_NS       1000
`define DRW_EEP_NS       10000
`define DRW_INS_NS       2000
`define DRW_CLK_NS       100
`define DRW_RAM_CYC      ((`DRW_RAM_NS + `DRW_CLK_NS - 1) / `DRW_CLK_NS)
`define DRW_EEP_CYC      ((`DRW_EEP_NS + `DRW_CLK_NS - 1) / `DRW_CLK_NS)
`define DRW_INS_CYC      ((`DRW_INS_NS + `DRW_CLK_NS - 1) / `DRW_CLK_NS)

`endif

// ==== drw_tb_top.sv ====
/* bench: apb master end facing the drive end over the link.
 assumes a 10 MHz clock and a short eeprom count. */
`timescale 1ns/100ps
`include "drw_regs.svh"
module drw_tb_top
	import drw_pkg::*;
;
	logic        core_clk_i = 1'h0;
	logic        rst_i = 1'h1;
	logic        psel_i = 1'h0;
	logic        penable_i = 1'h0;
	logic        pwrite_i = 1'h0;
	logic [7:0]  paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0;
	logic [7:0]  ext_i = 8'h00;
	logic [7:0]  src_i = 8'h00;
	logic        sens_i = 1'h0;
	logic        fault_i = 1'h0;
	logic [31:0] prdata_o, rd, cap;
	logic        pready_o, pslverr_o, ins_strobe_o, err;
	logic [15:0] mon_code_o, mon_data_i, fr_o, fe_o, tv_o, tp_o, op_o;
	logic [15:0] v, fr, tq;
	logic [7:0]  code_o, lext_o;
	int          fail_count = 0, total_checks = 0, strobes = 0, b;
	logic [7:0]  ext_t [5] = '{8'h00, 8'h01, 8'h0C, 8'h0C, 8'h02};
	logic [7:0]  src_t [5] = '{8'h03, 8'h05, 8'h03, 8'h05, 8'h03};
	drw_link_if lnk ();
	assign mon_data_i = mon_code_o ^ 16'h5A5A;
	always #50 core_clk_i = ~core_clk_i;
	drw_master drw_master_i (.core_clk_i, .rst_i, .clk_en_i(1'h1), .psel_i,
		.penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
		.pslverr_o, .lnk(lnk.master));
	drw_drive #(.EEP_CYC(5)) drw_drive_i (.core_clk_i, .rst_i, .clk_en_i(1'h1),
		.ext_setting_sel_i(ext_i), .torque_src_sel_i(src_i),
		.sensorless_vec_i(sens_i), .drive_fault_i(fault_i), .mon_code_o,
		.mon_data_i, .freq_ram_o(fr_o), .freq_eep_o(fe_o),
		.torque_cmd_volatile_param_o(tv_o),
		.torque_cmd_persistent_param_o(tp_o), .ins_strobe_o,
		.ins_code_o(code_o), .ins_link_ext_o(lext_o), .ins_operand_o(op_o),
		.lnk(lnk.drive));
	drw_link_sva drw_link_sva_i (.core_clk_i, .rst_i,
		.monitor_request(lnk.monitor_request),
		.ram_write_request(lnk.ram_write_request),
		.eeprom_write_request(lnk.eeprom_write_request),
		.instruction_execute_request(lnk.instruction_execute_request),
		.monitor_done(lnk.monitor_done), .ram_write_done(lnk.ram_write_done),
		.eeprom_write_done(lnk.eeprom_write_done),
		.instruction_done(lnk.instruction_done),
		.station_ready_flag(lnk.station_ready_flag));
	// strobe is one cycle wide, so catch it here
	always @(posedge core_clk_i) begin
		if (ins_strobe_o === 1'h1) begin
			strobes++;
			cap = {lext_o, code_o, op_o};
		end
	end
	task automatic chk(input string n, input logic [31:0] s, e);
		total_checks++;
		if (s !== e) begin
			fail_count++;
			$display("CHECK FAILED %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		psel_i <= 1'h1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge core_clk_i);
		penable_i <= 1'h1;
		do @(posedge core_clk_i); while (pready_o !== 1'h1);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'h0;
		penable_i <= 1'h0;
	endtask
	task automatic wait_st(input int i, input logic e);
		repeat (60) begin
			apb(1'h0, `DRW_A_STATUS, 32'h0);
			if (rd[i] === e) break;
		end
		chk("status bit", rd[i], e);
	endtask
	task automatic store(input int i, input logic [15:0] d);
		apb(1'h1, `DRW_A_WORD0 + 8'h04, {16'h0, d});
		apb(1'h1, `DRW_A_CTRL, 32'h1 << i);
		wait_st(i, 1'h1);
		apb(1'h1, `DRW_A_CTRL, 32'h0);
		wait_st(i, 1'h0);
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#(100 * 20000);
		fail_count++;
		close_out();
	end
	initial begin
		repeat (5) @(posedge core_clk_i);
		rst_i <= 1'h0;
		wait_st(4, 1'h1);
		for (int i = 0; i < 8; i++) begin
			v = (i == 0) ? 16'h0201 : 16'h1100 + 16'(i);
			apb(1'h1, 8'(i * 4), {16'h0, v});
			@(negedge core_clk_i);
			chk("link word", lnk.wr_word[i], v);
		end
		apb(1'h1, `DRW_A_CTRL, 32'h1);
		wait_st(0, 1'h1);
		for (int i = 0; i < 8; i++) begin
			if (i < 2 || i > 3) begin
				v = (i < 2) ? 16'(i + 1) : 16'h1100 + 16'(i);
				apb(1'h0, `DRW_A_RDBK0 + 8'(i * 4), 32'h0);
				chk("readback", rd, {16'h0, v ^ 16'h5A5A});
			end
		end
		apb(1'h1, `DRW_A_CTRL, 32'h0);
		store(1, `DRW_FREQ_MAX);
		chk("freq ram", fr_o, `DRW_FREQ_MAX);
		chk("freq eep", fe_o, 16'h0);
		store(2, `DRW_FREQ_MAX + 16'h1);
		chk("freq eep", fe_o, 16'h0);
		store(2, 16'h1234);
		chk("freq eep", fe_o, 16'h1234);
		// an eeprom store also refreshes the volatile copy
		fr = 16'h1234;
		for (int k = 0; k < 5; k++) begin
			ext_i <= ext_t[k];
			src_i <= src_t[k];
			sens_i <= (k != 3);
			b = 1 + (k & 1);
			v = 16'h0300 + 16'(k);
			store(b, v);
			if (k < 3) begin
				tq = v;
				chk("torque persist", tp_o, v);
				chk("freq kept", fr_o, fr);
			end else begin
				chk("freq", (b == 1) ? fr_o : fe_o, v);
				fr = v;
			end
			chk("torque volatile", tv_o, tq);
		end
		ext_i <= 8'h01;
		apb(1'h1, `DRW_A_WORD0 + 8'h08, 32'h03A5);
		apb(1'h1, `DRW_A_WORD0 + 8'h0C, 32'h0);
		chk("strobes", strobes, 0);
		apb(1'h1, `DRW_A_CTRL, 32'h8);
		wait_st(3, 1'h1);
		chk("strobes", strobes, 1);
		chk("instr fields", cap, 32'h03A50000);
		apb(1'h1, `DRW_A_CTRL, 32'h0);
		wait_st(3, 1'h0);
		apb(1'h0, 8'h80, 32'h0);
		chk("unmapped err", err, 1'h1);
		chk("unmapped data", rd, 32'h0);
		fault_i <= 1'h1;
		wait_st(4, 1'h0);
		apb(1'h1, `DRW_A_CTRL, 32'h1);
		@(negedge core_clk_i);
		chk("gated request", lnk.monitor_request, 1'h0);
		apb(1'h0, `DRW_A_CTRL, 32'h0);
		chk("ctrl held", rd, 32'h1);
		close_out();
	end
endmodule
